/* File: sdc_core.sv */
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "sdc_map.svh"
module sdc_core (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cke,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [1:0]  bank_select_bits,
    input  wire logic [12:0] addr,
    input  wire logic [1:0]  dqm,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic      [1:0]  dq_oe,
    input  wire logic [7:0]  die_temp,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    import sdc_pkg::*;

    sdc_cmd_type   cmd;
    sdc_state_type st, next_st;
    logic [9:0]  mode, next_mode;
    logic [6:0]  ext, next_ext;
    logic [12:0] open_row [0:3];
    logic [12:0] next_open_row [0:3];
    logic [1:0]  cur_bank, next_cur_bank;
    logic [1:0]  lat;
    logic        rd_cmd, wr_cmd, halt, sr_entry;
    logic        rd_beat, wr_beat, burst_last;
    logic [2:0]  burst_len;
    logic [8:0]  burst_col, beat_col;
    logic [1:0]  beat_bank;
    logic [14:0] mem_addr;
    logic [15:0] mem_rdata;
    logic        rv0, rv1, rv2, next_rv0, next_rv1, next_rv2;
    logic [15:0] rd1, rd2, next_rd1, next_rd2;
    logic [1:0]  dm0, dm1, next_dm0, next_dm1;
    logic        out_valid, next_out_valid;
    logic [15:0] next_dq_out;
    logic [1:0]  next_dq_oe;
    logic [7:0]  temp_s1, temp_s2, temp_s3;
    logic [1:0]  zone, next_zone;
    logic [12:0] sr_cnt, next_sr_cnt, sr_limit;
    logic [12:0] sr_row, next_sr_row;
    logic [1:0]  sr_bank, next_sr_bank, bank_max;
    logic [15:0] sr_done, next_sr_done;
    logic [1:0]  ctrl, next_ctrl;
    logic        next_wait;
    logic [31:0] next_readdata;
    logic        acc;

    // command pins are taken at the clock edge with no extra staging
    assign cmd = (cke && st != ST_SELF) ? sdc_decode(cs_n, ras_n, cas_n, we_n) : CMD_NOP;        // [RL1]
    assign sr_entry = !cke && st == ST_IDLE && sdc_decode(cs_n, ras_n, cas_n, we_n) == CMD_REF;
    assign rd_cmd = cmd == CMD_READ;
    assign wr_cmd = cmd == CMD_WR;
    assign halt   = cmd == CMD_STOP || cmd == CMD_PRE;                                        // [RL14]
    assign lat    = mode[`SDC_CL_LSB+1:`SDC_CL_LSB];
    assign burst_len = (wr_cmd && mode[`SDC_WBL_BIT]) ? 3'h0 : mode[`SDC_BL_MSB:`SDC_BL_LSB];  // [RL5]
    assign rd_beat = rd_cmd || (st == ST_READ && !halt && !wr_cmd);
    assign wr_beat = wr_cmd || (st == ST_WRITE && !halt && !rd_cmd);
    // a new column may come on any clock; it takes over at once
    assign beat_bank = (rd_cmd || wr_cmd) ? bank_select_bits : cur_bank;                     // [RL13]
    assign beat_col  = (rd_cmd || wr_cmd) ? addr[8:0] : burst_col;                            // [RL13]
    assign mem_addr  = {beat_bank, open_row[beat_bank][3:0], beat_col};                       // [RL6]

    sdc_burst u_burst (
        .clk        (clk),
        .rst        (rst),
        .start      (rd_cmd || wr_cmd),
        .start_col  (addr[8:0]),
        .len_code   (burst_len),
        .interleave (mode[`SDC_BT_BIT]),
        .col        (burst_col),
        .last       (burst_last)
    );

    // write mask acts on the same edge as the data
    sdc_mem u_mem (
        .clk   (clk),
        .addr  (mem_addr),
        .wr    (wr_beat),
        .be    (~dqm),                                                                          // [RL19]
        .wdata (dq_in),
        .rdata (mem_rdata)
    );

    // command state, mode words and open rows
    always_comb begin
        next_st       = st;
        next_mode     = mode;
        next_ext      = ext;
        next_cur_bank = cur_bank;
        next_open_row = open_row;
        case (st)
            ST_IDLE, ST_READ, ST_WRITE: begin
                if (sr_entry) begin
                    next_st = ST_SELF;
                end else if (rd_cmd) begin
                    next_st = (sdc_len_mask(burst_len) != 9'h000) ? ST_READ : ST_IDLE;        // [RL3]
                end else if (wr_cmd) begin
                    next_st = (sdc_len_mask(burst_len) != 9'h000) ? ST_WRITE : ST_IDLE;       // [RL5]
                end else if (halt || (st != ST_IDLE && burst_last)) begin
                    next_st = ST_IDLE;
                end
                if (rd_cmd || wr_cmd) begin
                    next_cur_bank = bank_select_bits;
                end
                if (cmd == CMD_ACT) begin
                    next_open_row[bank_select_bits] = addr;                                   // [RL6]
                end
                if (cmd == CMD_MODE && bank_select_bits == `SDC_BA_MODE) begin
                    next_mode = addr[9:0];
                    // reserved latency or length codes leave the old setting
                    if (!(addr[6:4] inside {3'h1, 3'h2, 3'h3})) begin
                        next_mode[6:4] = mode[6:4];                                           // [RL2]
                    end
                    if (addr[2] && !(addr[2:0] == 3'h7 && !addr[3])) begin
                        next_mode[3:0] = mode[3:0];                                           // [RL3]
                    end
                end else if (cmd == CMD_MODE && bank_select_bits == `SDC_BA_EXT) begin
                    next_ext = addr[6:0];                                                     // [RL16]
                end
            end
            ST_SELF: begin
                if (cke) begin
                    next_st = ST_IDLE;
                end
            end
            default: next_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st       <= ST_IDLE;
            mode     <= `SDC_MODE_RESET;
            ext      <= `SDC_EXT_RESET;
            cur_bank <= 2'h0;
            for (int i = 0; i < 4; i++) begin
                open_row[i] <= 13'h0000;
            end
        end else begin
            st       <= next_st;
            mode     <= next_mode;
            ext      <= next_ext;
            cur_bank <= next_cur_bank;
            open_row <= next_open_row;
        end
    end

    // read pipeline: output tap picked by the programmed latency
    always_comb begin
        next_rv0 = rd_beat;
        next_rv1 = rv0;
        next_rv2 = rv1;
        next_rd1 = mem_rdata;
        next_rd2 = rd1;
        next_dm0 = dqm;
        next_dm1 = dm0;
        case (lat)
            2'h1: begin
                next_out_valid = rv0;                                                         // [RL2]
                next_dq_out    = mem_rdata;
            end
            2'h2: begin
                next_out_valid = rv1;                                                         // [RL2]
                next_dq_out    = rd1;
            end
            default: begin
                next_out_valid = rv2;                                                         // [RL2]
                next_dq_out    = rd2;
            end
        endcase
        next_dq_oe = next_out_valid ? ~dm1 : 2'h0;                                            // [RL19]
        if (!next_out_valid) begin
            next_dq_out = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rv0       <= 1'b0;
            rv1       <= 1'b0;
            rv2       <= 1'b0;
            rd1       <= 16'h0000;
            rd2       <= 16'h0000;
            dm0       <= 2'h0;
            dm1       <= 2'h0;
            out_valid <= 1'b0;
            dq_out    <= 16'h0000;
            dq_oe     <= 2'h0;
        end else begin
            rv0       <= next_rv0;
            rv1       <= next_rv1;
            rv2       <= next_rv2;
            rd1       <= next_rd1;
            rd2       <= next_rd2;
            dm0       <= next_dm0;
            dm1       <= next_dm1;
            out_valid <= next_out_valid;
            dq_out    <= next_dq_out;
            dq_oe     <= next_dq_oe;
        end
    end

    // self refresh: interval stretched when the die is cool
    assign bank_max = (ext[`SDC_PARTIAL_ARRAY_SELF_REFRESH_MSB:`SDC_PARTIAL_ARRAY_SELF_REFRESH_LSB] == `SDC_PARTIAL_ARRAY_SELF_REFRESH_HALF) ? 2'h1 :
                      (ext[`SDC_PARTIAL_ARRAY_SELF_REFRESH_MSB:`SDC_PARTIAL_ARRAY_SELF_REFRESH_LSB] == `SDC_PARTIAL_ARRAY_SELF_REFRESH_QUARTER) ? 2'h0 : 2'h3;   // [RL16]
    assign sr_limit = (zone == 2'h0) ? 13'(`SDC_REFI_CYC * 4) :
                      (zone == 2'h1) ? 13'(`SDC_REFI_CYC * 2) : 13'(`SDC_REFI_CYC);             // [RL17]

    always_comb begin
        next_zone = 2'h2;
        if (temp_s2 < `SDC_TEMP_LOW) begin
            next_zone = 2'h0;                                                                  // [RL17]
        end else if (temp_s2 < (ctrl[`SDC_CTRL_EXTGRADE_BIT] ? `SDC_TEMP_EXT : `SDC_TEMP_COM)) begin
            next_zone = 2'h1;                                                                  // [RL17]
        end
        // a multi-bit reading caught mid-change is ignored until two samples agree
        if (temp_s2 != temp_s3) begin
            next_zone = zone;
        end
        next_sr_cnt  = 13'h0000;
        next_sr_row  = sr_row;
        next_sr_bank = sr_bank;
        next_sr_done = sr_done;
        if (sr_entry) begin
            next_sr_row  = 13'h0000;
            next_sr_bank = 2'h0;
        end else if (st == ST_SELF) begin
            next_sr_cnt = 13'(sr_cnt + 13'h0001);
            if (sr_cnt >= 13'(sr_limit - 13'h0001)) begin
                next_sr_cnt  = 13'h0000;
                next_sr_row  = 13'(sr_row + 13'h0001);
                next_sr_done = 16'(sr_done + 16'h0001);
                if (sr_row == 13'h1fff) begin
                    next_sr_bank = (sr_bank >= bank_max) ? 2'h0 : 2'(sr_bank + 2'h1);         // [RL16]
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            temp_s1 <= 8'h00;
            temp_s2 <= 8'h00;
            temp_s3 <= 8'h00;
            zone    <= 2'h2;
            sr_cnt  <= 13'h0000;
            sr_row  <= 13'h0000;
            sr_bank <= 2'h0;
            sr_done <= 16'h0000;
        end else begin
            temp_s1 <= die_temp;
            temp_s2 <= temp_s1;
            temp_s3 <= temp_s2;
            zone    <= next_zone;
            sr_cnt  <= next_sr_cnt;
            sr_row  <= next_sr_row;
            sr_bank <= next_sr_bank;
            sr_done <= next_sr_done;
        end
    end

    // register slave: waitrequest drops for one cycle per access
    assign acc = (avs_read || avs_write) && avs_waitrequest;

    always_comb begin
        next_wait     = !acc;
        next_ctrl     = ctrl;
        next_readdata = avs_readdata;
        if (avs_write && !avs_waitrequest && avs_address == `SDC_REG_CTRL) begin
            next_ctrl = avs_writedata[1:0];
        end
        if (acc) begin
            case (avs_address)
                `SDC_REG_MODE:  next_readdata = {22'h000000, mode};
                `SDC_REG_EXT:   next_readdata = {25'h0000000, ext};
                `SDC_REG_CTRL:  next_readdata = {30'h00000000, ctrl};
                `SDC_REG_STAT:  next_readdata = {25'h0000000,
                                                 lat == 2'h1 && !ctrl[`SDC_CTRL_LOWFREQ_BIT],
                                                 zone, st};
                `SDC_REG_SRCNT: next_readdata = {16'h0000, sr_done};
                default:        next_readdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl            <= `SDC_CTRL_RESET;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            ctrl            <= next_ctrl;
            avs_waitrequest <= next_wait;
            avs_readdata    <= next_readdata;
        end
    end

    sequence rd4_run_s;
        (rd_cmd && burst_len == 3'h2) ##1 (cmd == CMD_NOP && st == ST_READ)[*3];
    endsequence

    sequence stop3_s;
        (st == ST_READ && cmd == CMD_STOP && lat == 2'h3) ##1 (cmd == CMD_NOP)[*2];
    endsequence

    cmd_sample_a: assert property ( // [RL1]
        @(posedge clk) disable iff (rst) wr_cmd |-> (u_mem.wr && u_mem.be == ~dqm))
        else $error("write not taken on its edge");
    lat_one_a: assert property ( // [RL2]
        @(posedge clk) disable iff (rst) (rd_cmd && lat == 2'h1) |-> ##2 out_valid)
        else $error("latency one word late");
    lat_three_a: assert property ( // [RL2]
        @(posedge clk) disable iff (rst) (rd_cmd && lat == 2'h3) |-> ##4 out_valid)
        else $error("latency three word late");
    burst_four_a: assert property ( // [RL3]
        @(posedge clk) disable iff (rst) rd4_run_s |=> st == ST_IDLE)
        else $error("burst of four wrong length");
    single_write_a: assert property ( // [RL5]
        @(posedge clk) disable iff (rst) (wr_cmd && mode[`SDC_WBL_BIT]) |=> st != ST_WRITE)
        else $error("single write ran a burst");
    row_store_a: assert property ( // [RL6]
        @(posedge clk) disable iff (rst)
        cmd == CMD_ACT |=> open_row[$past(bank_select_bits)] == $past(addr))
        else $error("row not stored for bank");
    col_each_a: assert property ( // [RL13]
        @(posedge clk) disable iff (rst)
        (rd_cmd || wr_cmd) |-> (mem_addr[8:0] == addr[8:0] && mem_addr[14:13] == bank_select_bits))
        else $error("column command not taken at once");
    stop_tail_a: assert property ( // [RL14]
        @(posedge clk) disable iff (rst) stop3_s |-> ##1 out_valid ##1 !out_valid)
        else $error("cut read tail not two words");
    stop_none_a: assert property ( // [RL14]
        @(posedge clk) disable iff (rst) (cmd == CMD_STOP && lat == 2'h1) |-> ##2 !out_valid)
        else $error("cut read drove extra word");
    dqm_read_a: assert property ( // [RL19]
        @(posedge clk) disable iff (rst) out_valid |-> dq_oe == ~$past(dqm, 3))
        else $error("read mask latency not two");
    partial_array_self_refresh_bank_a: assert property ( // [RL16]
        @(posedge clk) disable iff (rst) st == ST_SELF |-> sr_bank <= bank_max)
        else $error("self refresh outside array part");
    temperature_compensated_refresh_zone_a: assert property ( // [RL17]
        @(posedge clk) disable iff (rst)
        (temp_s2 < `SDC_TEMP_LOW && temp_s2 == temp_s3) |=> sr_limit == 13'(`SDC_REFI_CYC * 4))
        else $error("cool die not slowed");
endmodule

/* File: sdc_map.svh */
// Notes on behaviour
// RL1: all inputs sampled on rising clock edge
// RL2: read latency one, two or three clocks
// RL3: burst lengths 1, 2, 4, 8, full page
// RL4: sequential or interleaved burst column order
// RL5: single-word writes while reads keep burst
// RL6: four banks, 13-bit rows, 9-bit columns; the store is addressed with row bits 3:0 only
// RL7: controller issues 8192 refreshes per 64 ms
// RL8: activates to other banks 15/18 ns apart
// RL9: precharge two clocks after last write word
// RL10: activate waits write recovery plus precharge time
// RL11: column command one clock after write word
// RL12: burst stop one clock after write word
// RL13: column command accepted every clock
// RL14: cut read gives latency-minus-one further words
// RL15: controller rounds nanosecond minimums up to clocks
// RL16: self refresh covers full, half, quarter array
// RL17: self refresh rate follows die temperature internally
// RL18: mode program all-precharged, then two-clock wait
// RL19: mask blocks write now, reads two later
// RL20: refresh only with all banks precharged
// RL21: auto precharge blocks bank until burst ends
// RL22: controller tracks per-bank timing in clocks
// RL23: controller spreads refreshes about 7.8 us apart
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

`define SDC_CLK_PERIOD_NS 4
`define SDC_REFI_NS 7800
`define SDC_REFI_CYC (`SDC_REFI_NS / `SDC_CLK_PERIOD_NS)

`define SDC_TEMP_LOW 8'h2d
`define SDC_TEMP_COM 8'h46
`define SDC_TEMP_EXT 8'h55

`define SDC_BL_MSB 2
`define SDC_BL_LSB 0
`define SDC_BT_BIT 3
`define SDC_CL_MSB 6
`define SDC_CL_LSB 4
`define SDC_WBL_BIT 9
`define SDC_PARTIAL_ARRAY_SELF_REFRESH_MSB 2
`define SDC_PARTIAL_ARRAY_SELF_REFRESH_LSB 0
`define SDC_MODE_RESET 10'h020
`define SDC_EXT_RESET 7'h00
`define SDC_BA_MODE 2'h0
`define SDC_BA_EXT 2'h2
`define SDC_PARTIAL_ARRAY_SELF_REFRESH_HALF 3'h1
`define SDC_PARTIAL_ARRAY_SELF_REFRESH_QUARTER 3'h2

`define SDC_REG_MODE 5'h00
`define SDC_REG_EXT 5'h04
`define SDC_REG_CTRL 5'h08
`define SDC_REG_STAT 5'h0c
`define SDC_REG_SRCNT 5'h10
`define SDC_CTRL_RESET 2'h0
`define SDC_CTRL_EXTGRADE_BIT 0
`define SDC_CTRL_LOWFREQ_BIT 1

`endif

/* File: sdc_pkg.sv */
package sdc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_SELF  = 4'b1000
    } sdc_state_type;

    typedef enum logic [2:0] {
        CMD_NOP  = 3'h0,
        CMD_ACT  = 3'h1,
        CMD_READ = 3'h2,
        CMD_WR   = 3'h3,
        CMD_STOP = 3'h4,
        CMD_PRE  = 3'h5,
        CMD_REF  = 3'h6,
        CMD_MODE = 3'h7
    } sdc_cmd_type;

    function automatic sdc_cmd_type sdc_decode(input logic cs_n, input logic ras_n,
                                               input logic cas_n, input logic we_n);
        sdc_cmd_type c;
        c = CMD_NOP;
        if (!cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'h3:    c = CMD_ACT;
                3'h5:    c = CMD_READ;
                3'h4:    c = CMD_WR;
                3'h6:    c = CMD_STOP;
                3'h2:    c = CMD_PRE;
                3'h1:    c = CMD_REF;
                3'h0:    c = CMD_MODE;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction

    // column mask of a burst; all ones means full page
    function automatic logic [8:0] sdc_len_mask(input logic [2:0] code);
        logic [8:0] m;
        case (code)
            3'h1:    m = 9'h001;
            3'h2:    m = 9'h003;
            3'h3:    m = 9'h007;
            3'h7:    m = 9'h1ff;
            default: m = 9'h000;
        endcase
        return m;
    endfunction

endpackage

/* File: sdc_mem.sv */
`timescale 1ns/1ps
module sdc_mem (
    input  wire logic        clk,
    input  wire logic [14:0] addr,
    input  wire logic        wr,
    input  wire logic [1:0]  be,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata
);
    logic [15:0] store [0:32767];

    always_ff @(posedge clk) begin
        if (wr && be[0]) begin
            store[addr][7:0] <= wdata[7:0];
        end
        if (wr && be[1]) begin
            store[addr][15:8] <= wdata[15:8];
        end
        rdata <= store[addr];
    end
endmodule

/* File: sdc_burst.sv */
`timescale 1ns/1ps
module sdc_burst (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire logic [8:0] start_col,
    input  wire logic [2:0] len_code,
    input  wire logic       interleave,
    output logic      [8:0] col,
    output logic            last
);
    import sdc_pkg::*;

    logic [8:0] base, next_base;
    logic [8:0] beat, next_beat;
    logic [8:0] mask, next_mask;
    logic       ilv, next_ilv;

    always_comb begin
        next_base = base;
        next_mask = mask;
        next_ilv  = ilv;
        next_beat = 9'(beat + 9'h001);
        if (start) begin
            next_base = start_col;
            next_mask = sdc_len_mask(len_code);
            next_ilv  = interleave;
            next_beat = 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            base <= 9'h000;
            beat <= 9'h000;
            mask <= 9'h000;
            ilv  <= 1'b0;
        end else begin
            base <= next_base;
            beat <= next_beat;
            mask <= next_mask;
            ilv  <= next_ilv;
        end
    end

    // columns wrap inside the block aligned to the burst length
    assign col = ilv ? ((base & ~mask) | ((base ^ beat) & mask))       // [RL4]
                     : ((base & ~mask) | (9'(base + beat) & mask));    // [RL4]
    assign last = (beat == mask) && (mask != 9'h1ff);                  // [RL3]

    ilv_order_a: assert property ( // [RL4]
        @(posedge clk) disable iff (rst)
        (ilv && mask == 9'h007) |-> (col[2:0] ^ base[2:0]) == beat[2:0])
        else $error("interleaved column order wrong");

    seq_order_a: assert property ( // [RL4]
        @(posedge clk) disable iff (rst)
        (!ilv && mask == 9'h003 && beat == 9'h001) |-> col[1:0] == 2'(base[1:0] + 2'h1))
        else $error("sequential column order wrong");
endmodule

/* File: sdc_host.sv */
`timescale 1ns/1ps
module sdc_host (
    input  wire logic   clk,
    output logic        cke,
    output logic        cs_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic [1:0]  bank_select_bits,
    output logic [12:0] addr,
    output logic [1:0]  dqm,
    output logic [15:0] dq_in
);
    import sdc_pkg::*;
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        ras_n = 1'b1;
        cas_n = 1'b1;
        we_n = 1'b1;
        bank_select_bits = 2'h0;
        addr = 13'h0000;
        dqm = 2'h0;
        dq_in = 16'h0000;
    end
    task automatic issue(input sdc_cmd_type c, input logic [1:0] b, input logic [12:0] a,
                         input logic [1:0] m, input logic [15:0] d);
        logic [2:0] p;
        case (c)
            CMD_ACT:  p = 3'h3;
            CMD_READ: p = 3'h5;
            CMD_WR:   p = 3'h4;
            CMD_STOP: p = 3'h6;
            CMD_PRE:  p = 3'h2;
            CMD_REF:  p = 3'h1;
            CMD_MODE: p = 3'h0;
            default:  p = 3'h7;
        endcase
        cs_n <= 1'b0;
        ras_n <= p[2];
        cas_n <= p[1];
        we_n <= p[0];
        bank_select_bits <= b;
        addr <= a;
        dqm <= m;
        dq_in <= d;
        @(posedge clk);
    endtask
    // released data lines toggle so stale data never looks valid
    task automatic nop(input int n);
        cs_n <= 1'b1;
        dq_in <= ~dq_in;
        repeat (n) @(posedge clk);
    endtask
    task automatic prog(input logic [1:0] b, input logic [12:0] k);
        nop(2);
        issue(CMD_PRE, 2'h1, 13'h0400, 2'h0, 16'h0);
        nop(6);
        issue(CMD_REF, 2'h0, 13'h0, 2'h0, 16'h0);
        nop(21);
        issue(CMD_MODE, b, k, 2'h0, 16'h0);
        nop(2);
        issue(CMD_ACT, 2'h1, 13'h0, 2'h0, 16'h0);
        nop(6);
    endtask
    task automatic set_cke(input logic v);
        cke <= v;
    endtask
endmodule

/* File: tb_sdc_core.sv */
`timescale 1ns/1ps
module tb_sdc_core;
    import sdc_pkg::*;
    typedef struct {logic [12:0] key; logic [8:0] col; int lat; int bl; logic il;} sdc_row_type;
    logic        clk, rst, cke, cs_n, ras_n, cas_n, we_n, avs_read, avs_write, avs_waitrequest;
    logic [1:0]  bank_select_bits, dqm, dq_oe;
    logic [12:0] addr;
    logic [15:0] dq_in, dq_out;
    logic [7:0]  die_temp;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    int          error_cnt = 0;
    int          tests_run = 0;
    sdc_row_type rows [5] = '{'{13'h022, 9'h06, 2, 4, 1'b0}, '{13'h03b, 9'h05, 3, 8, 1'b1},
        '{13'h011, 9'h03, 1, 2, 1'b0}, '{13'h033, 9'h0d, 3, 8, 1'b0}, '{13'h020, 9'h09, 2, 1, 1'b0}};
    logic [12:0] stop_key [2] = '{13'h0017, 13'h0037};
    logic [7:0]  temps [3] = '{8'd25, 8'd50, 8'd80};
    sdc_core i_sdc_core (.clk, .rst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_bits, .addr, .dqm,
        .dq_in, .dq_out, .dq_oe, .die_temp, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest);
    sdc_host i_sdc_host (.clk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_bits, .addr, .dqm, .dq_in);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [31:0] e);
        int n;
        n = 0;
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) chk(0, 1, "bus stall");
        if (!w) chk(avs_readdata, e, "reg read");
        @(posedge clk);
    endtask
    task automatic rdburst(input sdc_row_type r);
        logic [8:0] c, m;
        m = 9'(r.bl - 1);
        i_sdc_host.issue(CMD_READ, 2'h1, {4'h0, r.col}, 2'h0, 16'h0);
        i_sdc_host.nop(r.lat);
        for (int k = 0; k < r.bl; k++) begin
            c = r.il ? (r.col ^ 9'(k)) : ((r.col & ~m) | ((r.col + 9'(k)) & m));
            #1 chk({dq_oe, dq_out}, {2'h3, 16'ha000 + 16'(c)}, "burst word");
            @(posedge clk);
        end
        #1 chk(dq_oe, 0, "burst end");
        @(posedge clk);
    endtask
    task close_out;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
    initial begin
        int n;
        rst = 1'b1;
        die_temp = 8'd25;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        bus(0, 5'h00, 0, 32'h020);
        bus(0, 5'h04, 0, 0);
        bus(1, 5'h00, 32'hffff, 0);
        bus(0, 5'h00, 0, 32'h020);
        bus(1, 5'h08, 32'h2, 0);
        bus(0, 5'h08, 0, 32'h2);
        bus(0, 5'h14, 0, 0);
        // single-word writes: a burst would overwrite earlier columns
        i_sdc_host.prog(2'h0, 13'h0222);
        for (int c = 0; c < 16; c++) i_sdc_host.issue(CMD_WR, 2'h1, 13'(c), 2'h0, 16'ha000 + 16'(c));
        i_sdc_host.nop(1);
        foreach (rows[i]) begin
            i_sdc_host.prog(2'h0, rows[i].key);
            bus(0, 5'h00, 0, 32'(rows[i].key));
            rdburst(rows[i]);
        end
        i_sdc_host.prog(2'h0, 13'h0050);
        bus(0, 5'h00, 0, 32'h020);
        // full-page reads cut by a stop at latency one and three
        foreach (stop_key[i]) begin
            i_sdc_host.prog(2'h0, stop_key[i]);
            i_sdc_host.issue(CMD_READ, 2'h1, 13'h0, 2'h0, 16'h0);
            i_sdc_host.nop(1);
            i_sdc_host.issue(CMD_STOP, 2'h0, 13'h0, 2'h0, 16'h0);
            i_sdc_host.nop(1);
            n = 0;
            repeat (10) begin
                #1 n += (dq_oe != 2'h0);
                @(posedge clk);
            end
            chk(n, 2 * i, "words after stop");
        end
        i_sdc_host.prog(2'h0, 13'h0220);
        i_sdc_host.issue(CMD_WR, 2'h1, 13'h0, 2'h2, 16'h5555);
        i_sdc_host.issue(CMD_READ, 2'h1, 13'h0, 2'h2, 16'h0);
        i_sdc_host.nop(2);
        #1 chk({dq_oe, dq_out[7:0]}, {2'h1, 8'h55}, "masked read");
        @(posedge clk);
        // cool, mid and hot zones on the commercial thresholds
        foreach (temps[i]) begin
            die_temp <= temps[i];
            i_sdc_host.nop(6);
            bus(0, 5'h0c, 0, {26'h0, 2'(i), 4'h1});
        end
        bus(1, 5'h08, 32'h3, 0);
        bus(0, 5'h0c, 0, 32'h11);
        i_sdc_host.prog(2'h2, 13'h0001);
        bus(0, 5'h04, 0, 32'h1);
        i_sdc_host.issue(CMD_PRE, 2'h1, 13'h0400, 2'h0, 16'h0);
        i_sdc_host.nop(6);
        die_temp <= 8'd90;
        i_sdc_host.set_cke(1'b0);
        i_sdc_host.issue(CMD_REF, 2'h0, 13'h0, 2'h0, 16'h0);
        i_sdc_host.nop(2100);
        bus(0, 5'h10, 0, 32'h1);
        bus(0, 5'h0c, 0, 32'h28);
        rst <= 1'b1;
        i_sdc_host.set_cke(1'b1);
        i_sdc_host.nop(3);
        rst <= 1'b0;
        bus(0, 5'h00, 0, 32'h020);
        bus(0, 5'h10, 0, 0);
        close_out();
    end
endmodule
